// *** core/silo_dma_transfer_control.sv ***
`timescale 1ns/1ps
`include "silo_dma_regs.svh"
module silo_dma_transfer_control (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // controller control
   input  wire silo_dma_pkg::func_t  func,
   input  wire logic                 ctrl_ready,
   input  wire logic                 ctrl_clear,
   input  wire logic                 go_clear,
   input  wire logic [15:0]          csr1,
   input  wire logic                 error_clear,
   input  wire logic                 word_count_overflow,
   // memory bus handshake
   input  wire logic                 bus_grant,
   input  wire logic                 sync_wait_point,
   input  wire logic                 deskewed_master_sync,
   input  wire logic                 cycle_done,
   input  wire logic                 dma_master,
   input  wire logic                 first_bus_select,
   input  wire logic                 parity_jumper,
   output logic                      data_request,
   output logic                      bus_release,
   output logic                      next_cycle,
   output logic                      word_count_step,
   // memory bus data
   input  wire logic [17:0]          bus_a_data,
   input  wire logic [17:0]          bus_b_data,
   output logic [17:0]               bus_b_out,
   output logic                      bus_b_oe_n,
   output logic                      upper_bits_as_data,
   // drive side
   input  wire logic                 drive_exception,
   input  wire logic                 drive_strobe,
   input  wire logic [17:0]          drive_data,
   input  wire logic                 drive_parity,
   input  wire logic                 drive_take,
   output logic [17:0]               drive_out,
   output logic                      drive_out_parity,
   // status
   output logic                      drive_exception_error,
   output logic                      compare_error,
   output logic                      exception_saved,
   output logic                      output_buffer_full
);
   silo_dma_pkg::bus_state_t  st_r, st_nxt;
   silo_dma_pkg::silo_word_t  in_buf_r, out_buf_r, top_w, mux_w;
   logic       in_full_r, req_r, exc_d_r, exc_err_r, cmp_r, sec_r;
   logic       silo_input_ready, silo_output_ready, stop_pulse, xfer_pulse, xfer_done;

   // function decode
   wire logic is_write   = (func == silo_dma_pkg::FN_WRITE);
   wire logic is_rdchk   = (func == silo_dma_pkg::FN_READ) || (func == silo_dma_pkg::FN_WCHK);
   wire logic is_wchk    = (func == silo_dma_pkg::FN_WCHK);
   wire logic transfer_error = csr1[`CSR1_TRE_POS];
   wire logic silo_clr   = ctrl_clear || go_clear;
   wire logic exc_trail  = exc_d_r && !drive_exception;
   wire logic stop_seen  = silo_output_ready && top_w[`STOP_POS];
   // stop word enters once, at the edge that starts the stop pulse
   wire logic stop_push  = exc_trail && is_rdchk && !stop_pulse;
   // load strobe: input buffer word goes into the silo
   wire logic load_strobe = in_full_r && silo_input_ready && !stop_pulse && !stop_push;
   // unload strobe: top word moves into the output buffer; a stop word never does
   wire logic unload_ok  = silo_output_ready && !output_buffer_full && !xfer_pulse && !top_w[`STOP_POS];

   // data steering
   wire logic [17:0] bus_sel_w = (dma_master && !first_bus_select) ? bus_b_data : bus_a_data;
   assign upper_bits_as_data = !first_bus_select && !parity_jumper;
   wire logic [17:0] bus_b_w = upper_bits_as_data ? bus_b_data : {2'b00, bus_b_data[15:0]};
   wire logic [17:0] mem_w   = (dma_master && !first_bus_select) ? bus_b_w : bus_sel_w;
   always_comb begin
      if (is_rdchk) mux_w = {1'b0, drive_parity, drive_data};
      else          mux_w = {1'b0, 1'b0, is_write ? mem_w : bus_a_data};
   end

   // request conditions
   wire logic wr_req = is_write && !word_count_overflow && !transfer_error &&
                       (!in_full_r || load_strobe);
   wire logic rd_req = is_rdchk && output_buffer_full && !transfer_error;
   wire logic unlatch = bus_release || ctrl_ready || silo_clr;

   silo_store u_silo (
      .clk               (clk),
      .rstn              (rstn),
      .clear             (silo_clr),
      .push              (load_strobe || stop_push),
      .din               (stop_push ? {1'b1, 19'h00000} : in_buf_r),
      .silo_input_ready  (silo_input_ready),
      .pop               (unload_ok || xfer_done),
      .top_word          (top_w),
      .silo_output_ready (silo_output_ready)
   );

   pulse_stretch #(.CYCLES(`STOP_PULSE_CYC)) u_stop (
      .clk   (clk),
      .rstn  (rstn),
      .trig  (exc_trail && is_rdchk),
      .pulse (stop_pulse),
      .done  ()
   );

   pulse_stretch #(.CYCLES(`XFER_PULSE_CYC)) u_xfer (
      .clk   (clk),
      .rstn  (rstn),
      .trig  (stop_seen && !output_buffer_full),
      .pulse (xfer_pulse),
      .done  (xfer_done)
   );

   // bus cycle sequencer
   always_comb begin
      st_nxt      = st_r;
      bus_release = 1'b0;
      next_cycle  = 1'b0;
      case (st_r)
         silo_dma_pkg::BUS_IDLE:   if (req_r && bus_grant) st_nxt = silo_dma_pkg::BUS_CYCLE1;
         silo_dma_pkg::BUS_CYCLE1: begin
            if (sync_wait_point) begin
               next_cycle = is_write ? silo_input_ready : silo_output_ready;
            end
            if (cycle_done) st_nxt = sec_r ? silo_dma_pkg::BUS_CYCLE2 : silo_dma_pkg::BUS_REL;
         end
         silo_dma_pkg::BUS_CYCLE2: if (cycle_done) st_nxt = silo_dma_pkg::BUS_REL;
         silo_dma_pkg::BUS_REL: begin
            bus_release = 1'b1;
            st_nxt      = silo_dma_pkg::BUS_IDLE;
         end
         silo_dma_pkg::BUS_HALT: begin
            bus_release = 1'b1;
            st_nxt      = silo_dma_pkg::BUS_IDLE;
         end
         default: st_nxt = silo_dma_pkg::BUS_IDLE;
      endcase
      if (transfer_error && (st_r == silo_dma_pkg::BUS_CYCLE1 || st_r == silo_dma_pkg::BUS_CYCLE2))
         st_nxt = silo_dma_pkg::BUS_HALT;
   end

   always_ff @(posedge clk) begin
      if (!rstn || silo_clr) st_r <= silo_dma_pkg::BUS_IDLE;
      else st_r <= st_nxt;
   end

   // second-cycle decision taken at sync-wait of first cycle
   always_ff @(posedge clk) begin
      if (!rstn || st_r == silo_dma_pkg::BUS_IDLE) sec_r <= 1'b0;
      else if (st_r == silo_dma_pkg::BUS_CYCLE1 && sync_wait_point) sec_r <= next_cycle;
   end

   // request latch
   always_ff @(posedge clk) begin
      if (!rstn || silo_clr) req_r <= 1'b0;
      else if (wr_req || rd_req) req_r <= 1'b1;
      else if (unlatch) req_r <= 1'b0;
   end
   assign data_request = req_r && !transfer_error;

   // word counter step
   always_comb begin
      word_count_step = 1'b0;
      if (is_write) word_count_step = deskewed_master_sync && (st_r != silo_dma_pkg::BUS_IDLE);
      else if (is_rdchk) word_count_step = unload_ok && !top_w[`STOP_POS];
   end

   // input buffer: memory word latched on deskewed sync in write
   always_ff @(posedge clk) begin
      if (!rstn || silo_clr) begin
         in_full_r <= 1'b0;
         in_buf_r  <= 20'h00000;
      end else if (is_rdchk ? drive_strobe : (is_write && deskewed_master_sync)) begin
         in_full_r <= 1'b1;
         in_buf_r  <= mux_w;
      end else if (load_strobe) in_full_r <= 1'b0;
   end

   // output buffer
   always_ff @(posedge clk) begin
      if (!rstn || silo_clr) begin
         output_buffer_full <= 1'b0;
         out_buf_r          <= 20'h00000;
      end else if (unload_ok && !top_w[`STOP_POS]) begin
         output_buffer_full <= 1'b1;
         out_buf_r          <= top_w;
      end else if (drive_take || (is_rdchk && cycle_done && !compare_error)) begin
         output_buffer_full <= 1'b0;
      end
   end
   assign drive_out        = out_buf_r[17:0];
   assign drive_out_parity = out_buf_r[`PAR_POS];
   assign bus_b_out        = out_buf_r[17:0];
   assign bus_b_oe_n       = !(dma_master && !first_bus_select && is_rdchk && !is_wchk);

   // exception save and error
   always_ff @(posedge clk) begin
      if (!rstn) exc_d_r <= 1'b0;
      else exc_d_r <= drive_exception;
   end
   always_ff @(posedge clk) begin
      if (!rstn || silo_clr) begin
         exception_saved <= 1'b0;
         exc_err_r       <= 1'b0;
      end else begin
         if (exc_trail || (is_write && drive_exception)) exception_saved <= 1'b1;
         if ((is_write && exception_saved) ||
             (exception_saved && word_count_overflow) ||
             xfer_done)
            exc_err_r <= 1'b1;
      end
   end
   assign drive_exception_error = exc_err_r;

   // write-check compare
   assign cmp_r = (out_buf_r[17:0] != mem_w);
   always_ff @(posedge clk) begin
      if (!rstn) compare_error <= 1'b0;
      else if (is_wchk && sync_wait_point && output_buffer_full && cmp_r) compare_error <= 1'b1;
      else if (error_clear) compare_error <= 1'b0;
   end

   // assertions
   property p_req_latch;
      @(posedge clk) disable iff (!rstn)
      (req_r && !unlatch && !silo_clr) |=> req_r;
   endproperty
   a_req_latch: assert property (p_req_latch) else $error("request latch dropped");
   property p_rd_req;
      @(posedge clk) disable iff (!rstn)
      (rd_req && !silo_clr) |=> req_r;
   endproperty
   a_rd_req: assert property (p_rd_req) else $error("read request missing");
   property p_halt;
      @(posedge clk) disable iff (!rstn)
      (transfer_error && st_r == silo_dma_pkg::BUS_CYCLE1 && !silo_clr) |=> bus_release;
   endproperty
   a_halt: assert property (p_halt) else $error("error did not halt bus");
   property p_cmp;
      @(posedge clk) disable iff (!rstn)
      (is_wchk && sync_wait_point && output_buffer_full && cmp_r && !error_clear) |=> compare_error;
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare error not latched");
   property p_cmp_hold;
      @(posedge clk) disable iff (!rstn)
      (compare_error && !error_clear) |=> compare_error;
   endproperty
   a_cmp_hold: assert property (p_cmp_hold) else $error("compare error lost");
   property p_exc_wr;
      @(posedge clk) disable iff (!rstn)
      (is_write && exception_saved && !silo_clr) |=> drive_exception_error;
   endproperty
   a_exc_wr: assert property (p_exc_wr) else $error("write exception error late");
   property p_clear;
      @(posedge clk) disable iff (!rstn)
      silo_clr |=> (!req_r && !exception_saved);
   endproperty
   a_clear: assert property (p_clear) else $error("clear left state");
   property p_busb;
      @(posedge clk) disable iff (!rstn)
      !bus_b_oe_n |-> (dma_master && !first_bus_select);
   endproperty
   a_busb: assert property (p_busb) else $error("second bus driven wrongly");
   sequence s_first_wait;
      st_r == silo_dma_pkg::BUS_CYCLE1 && sync_wait_point && !silo_clr;
   endsequence
   sequence s_first_end;
      st_r == silo_dma_pkg::BUS_CYCLE1 && cycle_done && !transfer_error && !silo_clr;
   endsequence
   property p_two_cycles;
      @(posedge clk) disable iff (!rstn)
      (s_first_wait ##0 (is_write ? silo_input_ready : silo_output_ready)) |=> sec_r;
   endproperty
   a_two_cycles: assert property (p_two_cycles) else $error("second cycle not chosen");
   property p_release_one;
      @(posedge clk) disable iff (!rstn)
      (s_first_end ##0 !sec_r) |=> bus_release;
   endproperty
   a_release_one: assert property (p_release_one) else $error("single cycle kept the bus");
   property p_go_second;
      @(posedge clk) disable iff (!rstn)
      (s_first_end ##0 sec_r) |=> (st_r == silo_dma_pkg::BUS_CYCLE2);
   endproperty
   a_go_second: assert property (p_go_second) else $error("second cycle skipped");
   property p_release_two;
      @(posedge clk) disable iff (!rstn)
      (st_r == silo_dma_pkg::BUS_CYCLE2 && cycle_done && !transfer_error && !silo_clr) |=> bus_release;
   endproperty
   a_release_two: assert property (p_release_two) else $error("bus kept after second cycle");
   property p_halt_two;
      @(posedge clk) disable iff (!rstn)
      (transfer_error && st_r == silo_dma_pkg::BUS_CYCLE2 && !silo_clr) |=> bus_release;
   endproperty
   a_halt_two: assert property (p_halt_two) else $error("error did not halt second cycle");
   property p_wr_req;
      @(posedge clk) disable iff (!rstn)
      (is_write && !in_full_r && !word_count_overflow && !transfer_error && !silo_clr) |=> req_r;
   endproperty
   a_wr_req: assert property (p_wr_req) else $error("write request missing");
   property p_wc_read;
      @(posedge clk) disable iff (!rstn)
      (is_rdchk && $rose(output_buffer_full)) |-> $past(word_count_step);
   endproperty
   a_wc_read: assert property (p_wc_read) else $error("word count not stepped");
   property p_stop_push;
      @(posedge clk) disable iff (!rstn)
      (exc_trail && is_rdchk && !stop_pulse && !silo_clr) |=> (exception_saved && stop_pulse);
   endproperty
   a_stop_push: assert property (p_stop_push) else $error("stop word not started");
   property p_stop_no_full;
      @(posedge clk) disable iff (!rstn)
      (stop_seen && !output_buffer_full) |=> !output_buffer_full;
   endproperty
   a_stop_no_full: assert property (p_stop_no_full) else $error("stop word filled buffer");
   property p_stop_err;
      @(posedge clk) disable iff (!rstn || silo_clr)
      (stop_seen && !output_buffer_full && !xfer_pulse) |-> ##[1:4] drive_exception_error;
   endproperty
   a_stop_err: assert property (p_stop_err) else $error("stop word raised no error");
   property p_ovf_exc;
      @(posedge clk) disable iff (!rstn)
      (exception_saved && word_count_overflow && !silo_clr) |=> drive_exception_error;
   endproperty
   a_ovf_exc: assert property (p_ovf_exc) else $error("overflow exception late");
   property p_oe_read;
      @(posedge clk) disable iff (!rstn)
      (dma_master && !first_bus_select && func == silo_dma_pkg::FN_READ) |-> !bus_b_oe_n;
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("second bus not driven");
   property p_par_write;
      @(posedge clk) disable iff (!rstn)
      (is_write && $rose(output_buffer_full)) |-> !drive_out_parity;
   endproperty
   a_par_write: assert property (p_par_write) else $error("write parity not zero");
endmodule : silo_dma_transfer_control

// *** core/silo_dma_regs.svh ***
`ifndef SILO_DMA_REGS_SVH
`define SILO_DMA_REGS_SVH
// clock period and pulse widths
`define CLK_PERIOD_NS      25
`define STOP_PULSE_NS      150
`define STOP_PULSE_CYC     ((`STOP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define XFER_PULSE_NS      45
`define XFER_PULSE_CYC     ((`XFER_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// data path layout
`define DATA_W             18
`define PAR_POS            18
`define STOP_POS           19
`define SILO_W             20
`define SILO_DEPTH         64
`define SILO_AW            6
`define CSR1_TRE_POS       14
`endif

// *** core/silo_dma_pkg.sv ***
package silo_dma_pkg;
   typedef logic [19:0] silo_word_t;
   typedef enum logic [4:0] {
      BUS_IDLE   = 5'b00001,
      BUS_CYCLE1 = 5'b00010,
      BUS_CYCLE2 = 5'b00100,
      BUS_REL    = 5'b01000,
      BUS_HALT   = 5'b10000
   } bus_state_t;
   typedef enum logic [1:0] {
      FN_NONE  = 2'b00,
      FN_WRITE = 2'b01,
      FN_READ  = 2'b10,
      FN_WCHK  = 2'b11
   } func_t;
endpackage : silo_dma_pkg

// *** core/silo_store.sv ***
`timescale 1ns/1ps
`include "silo_dma_regs.svh"
// flip-flop silo: writes at the bottom, word appears at the top
module silo_store (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       clear,
   // fill side
   input  wire logic                       push,
   input  wire silo_dma_pkg::silo_word_t   din,
   output wire logic                       silo_input_ready,
   // drain side
   input  wire logic                       pop,
   output wire silo_dma_pkg::silo_word_t   top_word,
   output wire logic                       silo_output_ready
);
   silo_dma_pkg::silo_word_t mem_r [`SILO_DEPTH];
   logic [`SILO_AW:0]        wp_r;
   logic [`SILO_AW:0]        rp_r;
   wire  logic [`SILO_AW:0]  fill_w = wp_r - rp_r;
   wire  logic               do_push = push && silo_input_ready;
   wire  logic               do_pop  = pop && silo_output_ready;

   // status and top cell
   assign silo_input_ready  = (fill_w != 7'h40);
   assign silo_output_ready = (fill_w != 7'h00);
   assign top_word          = mem_r[rp_r[`SILO_AW-1:0]];

   // pointers
   always_ff @(posedge clk) begin
      if (!rstn || clear) begin
         wp_r <= 7'h00;
         rp_r <= 7'h00;
      end else begin
         if (do_push) wp_r <= wp_r + 7'h01;
         if (do_pop)  rp_r <= rp_r + 7'h01;
      end
   end

   // storage cells
   always_ff @(posedge clk) begin
      if (do_push) mem_r[wp_r[`SILO_AW-1:0]] <= din;
   end
endmodule : silo_store

// *** core/pulse_stretch.sv ***
`timescale 1ns/1ps
// one-shot: a trigger gives a pulse of a fixed number of cycles
module pulse_stretch #(
   parameter int unsigned CYCLES = 1
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // trigger and pulse
   input  wire logic trig,
   output wire logic pulse,
   output wire logic done
);
   logic [7:0] cnt_r;
   wire  logic last_w = (cnt_r == 8'h01);

   assign pulse = (cnt_r != 8'h00);
   assign done  = last_w;

   // count down from the width
   always_ff @(posedge clk) begin
      if (!rstn) cnt_r <= 8'h00;
      else if (trig && !pulse) cnt_r <= 8'(CYCLES);
      else if (pulse) cnt_r <= cnt_r - 8'h01;
   end
endmodule : pulse_stretch

// *** verification/mem_bus_model.sv ***
`timescale 1ns/1ps
// memory bus partner: answers each request with one or two dma cycles
module mem_bus_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        slow,
   // request side of the block
   input  wire logic        data_request,
   input  wire logic        next_cycle,
   // bus handshake and data
   output logic             bus_grant,
   output logic             sync_wait_point,
   output logic             deskewed_master_sync,
   output logic             cycle_done,
   output logic [17:0]      bus_a_data,
   output logic [17:0]      bus_b_data
);
   int unsigned n;
   int          i;
   int          k;
   logic        again;
   // memory word n is 2_0000+n on the first bus and 1_0000+n on the second
   initial begin
      {bus_grant, sync_wait_point, deskewed_master_sync, cycle_done} = 4'h0;
      bus_a_data = 18'h3ffff;
      bus_b_data = 18'h3ffff;
      n = 0;
      forever begin
         @(negedge clk);
         if (rstn === 1'b1 && data_request === 1'b1) begin
            for (i = 0; i < (slow ? 4 : 0); i++) @(negedge clk);
            bus_grant = 1'b1;
            @(negedge clk);
            bus_grant = 1'b0;
            again = 1'b1;
            // a second cycle only when the block asks at sync wait
            for (k = 0; k < 2 && again; k++) begin
               bus_a_data = 18'h20000 | n[17:0];
               bus_b_data = 18'h10000 | n[17:0];
               @(negedge clk);
               sync_wait_point = 1'b1;
               deskewed_master_sync = 1'b1;
               @(posedge clk);
               again = (next_cycle === 1'b1);
               @(negedge clk);
               {sync_wait_point, deskewed_master_sync, cycle_done} = 3'b001;
               @(negedge clk);
               cycle_done = 1'b0;
               // released lines no longer hold the last word
               bus_a_data = ~bus_a_data;
               bus_b_data = ~bus_b_data;
               n++;
            end
            // give the block time to drop its request
            for (i = 0; i < 4 && data_request === 1'b1; i++) @(negedge clk);
         end
      end
   end
endmodule : mem_bus_model

// *** verification/tb_silo_dma_transfer_control.sv ***
`timescale 1ns/1ps
module tb_silo_dma_transfer_control;
   logic clk, rstn, ctrl_ready, ctrl_clear, go_clear, error_clear, word_count_overflow, slow;
   logic bus_grant, sync_wait_point, deskewed_master_sync, cycle_done, dma_master, first_bus_select;
   logic parity_jumper, data_request, bus_release, next_cycle, word_count_step, bus_b_oe_n;
   logic upper_bits_as_data, drive_exception, drive_strobe, drive_parity, drive_take, drive_out_parity;
   logic drive_exception_error, compare_error, exception_saved, output_buffer_full, en_wc;
   logic [15:0] csr1;
   logic [17:0] bus_a_data, bus_b_data, bus_b_out, drive_data, drive_out;
   silo_dma_pkg::func_t func;
   int n_errors = 0;
   int comparisons = 0;
   int n_step = 0;
   int n_rel = 0;
   int s0, r0;
   // design and memory partner
   silo_dma_transfer_control dut (.clk, .rstn, .func, .ctrl_ready, .ctrl_clear, .go_clear, .csr1,
      .error_clear, .word_count_overflow, .bus_grant, .sync_wait_point, .deskewed_master_sync,
      .cycle_done, .dma_master, .first_bus_select, .parity_jumper, .data_request, .bus_release,
      .next_cycle, .word_count_step, .bus_a_data, .bus_b_data, .bus_b_out, .bus_b_oe_n,
      .upper_bits_as_data, .drive_exception, .drive_strobe, .drive_data, .drive_parity, .drive_take,
      .drive_out, .drive_out_parity, .drive_exception_error, .compare_error, .exception_saved,
      .output_buffer_full);
   mem_bus_model u_mem (.clk, .rstn, .slow, .data_request, .next_cycle, .bus_grant,
      .sync_wait_point, .deskewed_master_sync, .cycle_done, .bus_a_data, .bus_b_data);
   // clock
   always #12.5 clk = ~clk;
   // word counter watch
   always @(posedge clk) begin
      if (word_count_step === 1'b1) n_step++;
      if (bus_release === 1'b1) n_rel++;
      if (en_wc) chk("word_count_step", {17'h0, deskewed_master_sync}, {17'h0, word_count_step});
   end
   task stop_test;
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic pick(input int w);
      case (w)
         0: return output_buffer_full;
         1: return data_request;
         2: return bus_b_oe_n;
         3: return exception_saved;
         4: return drive_exception_error;
         default: return compare_error;
      endcase
   endfunction : pick
   // bounded wait for a status output to reach a level
   task wait_for(input int w, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && pick(w) !== v; i++) @(negedge clk);
      comparisons++;
      if (pick(w) !== v) begin
         n_errors++;
         $display("[ERR] status %0d expected %b seen %b", w, v, pick(w));
         stop_test();
      end
   endtask : wait_for
   task clear_all;
      @(negedge clk);
      func = silo_dma_pkg::FN_NONE;
      ctrl_clear = 1'b1;
      @(negedge clk);
      ctrl_clear = 1'b0;
      repeat (8) @(negedge clk);
   endtask : clear_all
   task strobe_word(input logic [17:0] d, input logic p);
      @(negedge clk);
      {drive_data, drive_parity, drive_strobe} = {d, p, 1'b1};
      @(negedge clk);
      {drive_data, drive_parity, drive_strobe} = {~d, ~p, 1'b0};
   endtask : strobe_word
   task t_reset;
      chk("data_request", 18'h0, {17'h0, data_request});
      chk("output_buffer_full", 18'h0, {17'h0, output_buffer_full});
      chk("exception_saved", 18'h0, {17'h0, exception_saved});
      chk("bus_b_oe_n", 18'h1, {17'h0, bus_b_oe_n});
   endtask : t_reset
   // write from the first bus, slow memory, words reach the drive in order
   task t_write;
      {dma_master, first_bus_select, slow, en_wc} = 4'hf;
      func = silo_dma_pkg::FN_WRITE;
      wait_for(1, 1'b1, 10);
      wait_for(0, 1'b1, 300);
      chk("drive_out", 18'h20000, drive_out);
      chk("drive_out_parity", 18'h0, {17'h0, drive_out_parity});
      chk("bus_b_oe_n", 18'h1, {17'h0, bus_b_oe_n});
      drive_take = 1'b1;
      @(negedge clk);
      drive_take = 1'b0;
      repeat (6) @(negedge clk);
      wait_for(0, 1'b1, 300);
      chk("drive_out", 18'h20001, drive_out);
      drive_exception = 1'b1;
      wait_for(4, 1'b1, 4);
      drive_exception = 1'b0;
      csr1[14] = 1'b1;
      en_wc = 1'b0;
      wait_for(1, 1'b0, 3);
      repeat (20) @(negedge clk);
      chk("data_request", 18'h0, {17'h0, data_request});
      csr1[14] = 1'b0;
      clear_all();
      chk("exception_saved", 18'h0, {17'h0, exception_saved});
   endtask : t_write
   // read to the second bus, then an exception drains behind a stop word
   task t_read;
      {first_bus_select, slow} = 2'b00;
      func = silo_dma_pkg::FN_READ;
      s0 = n_step;
      r0 = n_rel;
      for (int k = 0; k < 3; k++) strobe_word(18'h15555 + 18'(k), 1'b1);
      wait_for(1, 1'b1, 20);
      wait_for(2, 1'b0, 20);
      chk("bus_b_out", 18'h15555, bus_b_out);
      chk("drive_out_parity", 18'h1, {17'h0, drive_out_parity});
      repeat (200) @(negedge clk);
      chk("word_count_step", 18'd3, 18'(n_step - s0));
      chk("bus_release", 18'h2, 18'(n_rel - r0));
      drive_exception = 1'b1;
      @(negedge clk);
      drive_exception = 1'b0;
      wait_for(3, 1'b1, 4);
      wait_for(4, 1'b1, 100);
      clear_all();
      func = silo_dma_pkg::FN_READ;
      word_count_overflow = 1'b1;
      drive_exception = 1'b1;
      @(negedge clk);
      drive_exception = 1'b0;
      wait_for(4, 1'b1, 3);
      word_count_overflow = 1'b0;
      clear_all();
   endtask : t_read
   // write-check mismatch latches until error clear
   task t_wchk;
      first_bus_select = 1'b1;
      func = silo_dma_pkg::FN_WCHK;
      strobe_word(18'h00001, 1'b0);
      wait_for(5, 1'b1, 200);
      error_clear = 1'b1;
      @(negedge clk);
      error_clear = 1'b0;
      wait_for(5, 1'b0, 4);
      clear_all();
   endtask : t_wchk
   // upper second-bus lines and driver enable
   task t_lines;
      {first_bus_select, parity_jumper} = 2'b10;
      @(negedge clk);
      chk("upper_bits_as_data", 18'h0, {17'h0, upper_bits_as_data});
      {first_bus_select, parity_jumper} = 2'b00;
      @(negedge clk);
      chk("upper_bits_as_data", 18'h1, {17'h0, upper_bits_as_data});
      parity_jumper = 1'b1;
      @(negedge clk);
      chk("upper_bits_as_data", 18'h0, {17'h0, upper_bits_as_data});
      dma_master = 1'b0;
      func = silo_dma_pkg::FN_READ;
      repeat (4) @(negedge clk);
      chk("bus_b_oe_n", 18'h1, {17'h0, bus_b_oe_n});
      clear_all();
   endtask : t_lines
   initial begin
      {clk, rstn, ctrl_ready, ctrl_clear, go_clear, error_clear, word_count_overflow} = 7'h0;
      {dma_master, first_bus_select, parity_jumper, drive_exception, drive_strobe} = 5'h0;
      {drive_parity, drive_take, en_wc, slow} = 4'h0;
      {csr1, drive_data} = 34'h0;
      func = silo_dma_pkg::FN_NONE;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      t_reset();
      t_write();
      t_read();
      t_wchk();
      t_lines();
      stop_test();
   end
endmodule : tb_silo_dma_transfer_control
